// file: rtl/abx_core.sv
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps

// Summary of operation
// RULE1: Register AND: accumulator AND addressed register, negative and zero flags updated.
// RULE2: Register AND is decoded from top six bits 000101, then d, a, address.
// RULE3: Destination bit 0 writes the accumulator; the register is left alone.
// RULE4: Destination bit 1 writes the result back to the addressed register.
// RULE5: Access bit 0 picks the access bank; 1 takes bank from bank select.
// RULE6: Access 0, extended set on, address up to 95: indexed offset addressing.
// RULE7: Branch on carry set: PC+2+2n when carry is 1; flags unchanged.
// RULE8: Bit clear forces the chosen bit 0 to 7 of the register to 0.
// RULE9: Bit clear uses the same access, banked and indexed address selection.
// RULE10: Register AND is one word and finishes in one instruction cycle.
// RULE11: Phases: decode, read source, process, write destination.
// RULE12: Literal AND puts accumulator AND literal in accumulator, updates N and Z.
// RULE13: Untaken branch takes one cycle; taken branch adds one no-operation cycle.

module abx_core (
    input  wire logic        CLK,        // Core clock, 250 MHz.
    input  wire logic        RST,        // Synchronous reset, active high.
    output logic      [20:0] PM_ADDR,    // Program memory fetch address.
    input  wire logic [15:0] PM_DATA,    // Program word at PM_ADDR.
    output logic      [11:0] DR_ADDR,    // Data register address.
    output logic             DR_RE,      // Data register read strobe.
    input  wire logic [7:0]  DR_RDATA,   // Read data, cycle after DR_RE.
    output logic             DR_WE,      // Data register write strobe.
    output logic      [7:0]  DR_WDATA,   // Data register write data.
    input  wire logic [7:0]  REG_ADDR,   // Control port address.
    input  wire logic [7:0]  REG_WDATA,  // Control port write data.
    input  wire logic        REG_WR,     // Control port write strobe.
    input  wire logic        REG_RD,     // Control port read strobe.
    output logic      [7:0]  REG_RDATA   // Control port read data.
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    abx_pkg::abx_phase_e          phase;
    logic [abx_pkg::PC_W-1:0]     pc;
    logic [15:0]                  ir;
    logic                         ir_valid;
    logic [7:0]                   acc;
    logic [7:0]                   result;
    logic                         flag_c;
    logic                         flag_z;
    logic                         flag_n;
    logic                         run;
    logic                         ext_en;
    logic [3:0]                   bank_select_register;
    logic [11:0]                  idx_base;

    logic                         is_and_lit;
    logic                         is_and_reg;
    logic                         is_br_carry;
    logic                         is_bit_clear;
    logic                         dest_reg;
    logic                         taken;
    logic [11:0]                  sel_addr;
    logic [7:0]                   next_result;
    logic [abx_pkg::PC_W-1:0]     br_offset;

    // ----------------------------------------------------------------
    // Phase sequencer
    // ----------------------------------------------------------------
    // A new instruction cycle only starts while run is set, so halting
    // always lands cleanly between instructions.
    always_ff @(posedge CLK) begin
        if (RST) begin
            phase <= abx_pkg::ABX_Q1;
        end else begin
            unique case (phase)
                abx_pkg::ABX_Q1: begin
                    if (run) begin
                        phase <= abx_pkg::ABX_Q2;                    // RULE11
                    end
                end
                abx_pkg::ABX_Q2: begin
                    phase <= abx_pkg::ABX_Q3;
                end
                abx_pkg::ABX_Q3: begin
                    phase <= abx_pkg::ABX_Q4;
                end
                abx_pkg::ABX_Q4: begin
                    phase <= abx_pkg::ABX_Q1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    always_comb begin
        is_and_lit   = ir_valid && ir[15:8] == abx_pkg::OPC_AND_LIT;   // RULE12
        is_and_reg   = ir_valid && ir[15:10] == abx_pkg::OPC_AND_REG;  // RULE2
        is_br_carry  = ir_valid && ir[15:8] == abx_pkg::OPC_BR_CARRY;  // RULE7
        is_bit_clear = ir_valid && ir[15:12] == abx_pkg::OPC_BIT_CLEAR; // RULE8
        dest_reg     = ir[abx_pkg::POS_DEST];
        taken        = is_br_carry && flag_c;                           // RULE7
        br_offset    = {{12{ir[7]}}, ir[7:0], 1'b0};
    end

    abx_addr_sel u_addr_sel (
        .f_addr   (ir[7:0]),
        .access   (ir[abx_pkg::POS_ACCESS]),
        .bank     (bank_select_register),
        .ext_en   (ext_en),
        .idx_base (idx_base),
        .addr     (sel_addr),
        .indexed  ()
    );

    // ----------------------------------------------------------------
    // Data path
    // ----------------------------------------------------------------
    always_comb begin
        next_result = 8'h00;
        if (is_and_reg) begin
            next_result = acc & DR_RDATA;                              // RULE1
        end else if (is_bit_clear) begin
            next_result = DR_RDATA & ~(8'h01 << ir[11:9]);             // RULE8
        end else if (is_and_lit) begin
            next_result = acc & ir[7:0];                               // RULE12
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            result <= 8'h00;
        end else if (phase == abx_pkg::ABX_Q3) begin
            result <= next_result;                                     // RULE11
        end
    end

    // ----------------------------------------------------------------
    // Data register port
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            DR_ADDR <= 12'h000;
            DR_RE   <= 1'b0;
        end else if (phase == abx_pkg::ABX_Q1 && run) begin
            DR_ADDR <= sel_addr;                                       // RULE9
            DR_RE   <= is_and_reg || is_bit_clear;                     // RULE11
        end else begin
            DR_RE   <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            DR_WE    <= 1'b0;
            DR_WDATA <= 8'h00;
        end else if (phase == abx_pkg::ABX_Q3) begin
            DR_WDATA <= next_result;
            DR_WE    <= is_bit_clear || (is_and_reg && dest_reg);      // RULE4
        end else begin
            DR_WE    <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Accumulator and flags
    // ----------------------------------------------------------------
    // The core's own update at the end of the write phase wins over a
    // software write in the same cycle.
    always_ff @(posedge CLK) begin
        if (RST) begin
            acc <= abx_pkg::ACC_RST;
        end else if (phase == abx_pkg::ABX_Q4
                     && (is_and_lit || (is_and_reg && !dest_reg))) begin
            acc <= result;                                             // RULE3
        end else if (REG_WR && REG_ADDR == abx_pkg::REG_ACC) begin
            acc <= REG_WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            flag_n <= 1'b0;
            flag_z <= 1'b0;
        end else if (phase == abx_pkg::ABX_Q4 && (is_and_lit || is_and_reg)) begin
            flag_n <= result[7];                                       // RULE1
            flag_z <= result == 8'h00;                                 // RULE12
        end else if (REG_WR && REG_ADDR == abx_pkg::REG_STATUS) begin
            flag_n <= REG_WDATA[abx_pkg::STAT_N];
            flag_z <= REG_WDATA[abx_pkg::STAT_Z];
        end
    end

    // Carry is only read by the core, never written by these instructions.
    always_ff @(posedge CLK) begin
        if (RST) begin
            flag_c <= 1'b0;
        end else if (REG_WR && REG_ADDR == abx_pkg::REG_STATUS) begin
            flag_c <= REG_WDATA[abx_pkg::STAT_C];
        end
    end

    // ----------------------------------------------------------------
    // Program counter and fetch
    // ----------------------------------------------------------------
    // The counter already points at the next word, so a taken branch adds
    // twice the offset to it; the word fetched alongside is discarded and
    // its cycle runs as a no-operation.
    always_ff @(posedge CLK) begin
        if (RST) begin
            pc       <= abx_pkg::PC_RST;
            ir       <= 16'h0000;
            ir_valid <= 1'b0;
        end else if (phase == abx_pkg::ABX_Q4) begin
            ir <= PM_DATA;
            if (taken) begin
                pc       <= pc + br_offset;                            // RULE7
                ir_valid <= 1'b0;                                      // RULE13
            end else begin
                pc       <= pc + abx_pkg::PC_STEP;                     // RULE10
                ir_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            PM_ADDR <= abx_pkg::PC_RST;
        end else if (phase == abx_pkg::ABX_Q4) begin
            PM_ADDR <= taken ? pc + br_offset : pc + abx_pkg::PC_STEP;
        end
    end

    // ----------------------------------------------------------------
    // Control port
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            run    <= abx_pkg::CTRL_RST[abx_pkg::CTRL_RUN];
            ext_en <= abx_pkg::CTRL_RST[abx_pkg::CTRL_EXT];
        end else if (REG_WR && REG_ADDR == abx_pkg::REG_CTRL) begin
            run    <= REG_WDATA[abx_pkg::CTRL_RUN];
            ext_en <= REG_WDATA[abx_pkg::CTRL_EXT];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            bank_select_register <= 4'h0;
            idx_base             <= 12'h000;
        end else if (REG_WR) begin
            if (REG_ADDR == abx_pkg::REG_BANK) begin
                bank_select_register <= REG_WDATA[3:0];
            end
            if (REG_ADDR == abx_pkg::REG_IDX_LO) begin
                idx_base[7:0] <= REG_WDATA;
            end
            if (REG_ADDR == abx_pkg::REG_IDX_HI) begin
                idx_base[11:8] <= REG_WDATA[3:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                abx_pkg::REG_CTRL:   REG_RDATA <= {6'h00, ext_en, run};
                abx_pkg::REG_ACC:    REG_RDATA <= acc;
                abx_pkg::REG_STATUS: REG_RDATA <= {3'h0, flag_n, 1'b0, flag_z,
                                                   1'b0, flag_c};
                abx_pkg::REG_BANK:   REG_RDATA <= {4'h0, bank_select_register};
                abx_pkg::REG_IDX_LO: REG_RDATA <= idx_base[7:0];
                abx_pkg::REG_IDX_HI: REG_RDATA <= {4'h0, idx_base[11:8]};
                abx_pkg::REG_PC_LO:  REG_RDATA <= pc[7:0];
                abx_pkg::REG_PC_MID: REG_RDATA <= pc[15:8];
                abx_pkg::REG_PC_HI:  REG_RDATA <= {3'h0, pc[20:16]};
                default:             REG_RDATA <= 8'h00;
            endcase
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

endmodule : abx_core

// file: inc/abx_pkg.sv
package abx_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PC_W   = 21;
    localparam int DA_W   = 12;
    localparam int RA_W   = 8;

    // ----------------------------------------------------------------
    // Opcode fields
    // ----------------------------------------------------------------
    localparam logic [7:0] OPC_AND_LIT   = 8'h0b;
    localparam logic [5:0] OPC_AND_REG   = 6'h05;
    localparam logic [7:0] OPC_BR_CARRY  = 8'he2;
    localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
    localparam int         POS_DEST      = 9;
    localparam int         POS_ACCESS    = 8;

    // ----------------------------------------------------------------
    // Address selection
    // ----------------------------------------------------------------
    localparam logic [7:0] ACCESS_SPLIT  = 8'h60;
    localparam logic [3:0] ACCESS_HI_BNK = 4'hf;
    localparam logic [3:0] ACCESS_LO_BNK = 4'h0;

    // ----------------------------------------------------------------
    // Register map of the control port
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ACC    = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_BANK   = 8'h03;
    localparam logic [7:0] REG_IDX_LO = 8'h04;
    localparam logic [7:0] REG_IDX_HI = 8'h05;
    localparam logic [7:0] REG_PC_LO  = 8'h06;
    localparam logic [7:0] REG_PC_MID = 8'h07;
    localparam logic [7:0] REG_PC_HI  = 8'h08;

    localparam int CTRL_RUN = 0;
    localparam int CTRL_EXT = 1;
    localparam int STAT_C   = 0;
    localparam int STAT_Z   = 2;
    localparam int STAT_N   = 4;

    localparam logic [1:0]      CTRL_RST = 2'h0;
    localparam logic [7:0]      ACC_RST  = 8'h00;
    localparam logic [PC_W-1:0] PC_RST   = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;

    // ----------------------------------------------------------------
    // Instruction cycle phases
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ABX_Q1 = 2'b00,
        ABX_Q2 = 2'b01,
        ABX_Q3 = 2'b10,
        ABX_Q4 = 2'b11
    } abx_phase_e;

endpackage : abx_pkg

// file: rtl/abx_addr_sel.sv
`timescale 1ns/1ps

// --------------------------------------------------------------------
// Operand address selection
// --------------------------------------------------------------------
module abx_addr_sel (
    input  wire logic [7:0]  f_addr,     // Register address field.
    input  wire logic        access,     // Access bit of the word.
    input  wire logic [3:0]  bank,       // Bank select register.
    input  wire logic        ext_en,     // Extended set enabled.
    input  wire logic [11:0] idx_base,   // Base of indexed offset mode.
    output logic      [11:0] addr,       // Resolved data address.
    output logic             indexed     // Indexed mode in use.
);

    always_comb begin
        indexed = 1'b0;
        if (access) begin
            addr = {bank, f_addr};                                   // RULE5
        end else if (ext_en && f_addr < abx_pkg::ACCESS_SPLIT) begin
            indexed = 1'b1;
            addr    = idx_base + {4'h0, f_addr};                     // RULE6
        end else if (f_addr < abx_pkg::ACCESS_SPLIT) begin
            addr = {abx_pkg::ACCESS_LO_BNK, f_addr};                 // RULE5
        end else begin
            addr = {abx_pkg::ACCESS_HI_BNK, f_addr};                 // RULE5
        end
    end

endmodule : abx_addr_sel

// file: testbench/abx_core_properties.sv
`timescale 1ns/1ps

module abx_core_properties (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [20:0] PM_ADDR,
    input wire logic [15:0] PM_DATA,
    input wire logic [11:0] DR_ADDR,
    input wire logic        DR_RE,
    input wire logic [7:0]  DR_RDATA,
    input wire logic        DR_WE,
    input wire logic [7:0]  DR_WDATA,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_RDATA
);
    // ----------------------------------------------------------------
    // Shadow of the word in execution and of software settings
    // ----------------------------------------------------------------
    logic [15:0] ir;
    logic [3:0]  bank;
    logic        ext;
    logic        carry;
    logic [11:0] base;

    // A fetch address change marks the end of Q4, so the old word is the new instruction.
    always_ff @(posedge CLK) begin
        if (RST) begin
            ir <= 16'h0000;
        end else if ($changed(PM_ADDR)) begin
            ir <= $past(PM_DATA);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            bank  <= 4'h0;
            ext   <= 1'b0;
            carry <= 1'b0;
            base  <= 12'h000;
        end else if (REG_WR) begin
            if (REG_ADDR == abx_pkg::REG_BANK) bank <= REG_WDATA[3:0];
            if (REG_ADDR == abx_pkg::REG_CTRL) ext <= REG_WDATA[abx_pkg::CTRL_EXT];
            if (REG_ADDR == abx_pkg::REG_STATUS) carry <= REG_WDATA[abx_pkg::STAT_C];
            if (REG_ADDR == abx_pkg::REG_IDX_LO) base[7:0] <= REG_WDATA;
            if (REG_ADDR == abx_pkg::REG_IDX_HI) base[11:8] <= REG_WDATA[3:0];
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_write_after_read: assert property (DR_WE |-> $past(DR_RE, 2))
        else $error("register write without read two cycles before");
    a_read_once_per: assert property (DR_RE |=> !DR_RE ##1 !DR_RE ##1 !DR_RE)
        else $error("second register read within one instruction cycle");
    a_dest_reg_write: assert property (DR_RE && (ir[15:12] == 4'h9
        || (ir[15:10] == 6'h05 && ir[9])) |-> ##2 DR_WE)
        else $error("register destination not written in Q4");
    a_dest_acc_only: assert property (DR_RE && ir[15:10] == 6'h05 && !ir[9]
        |-> ##2 !DR_WE)
        else $error("register written although destination is accumulator");
    a_bank_addr: assert property (DR_RE && ir[8] |-> DR_ADDR == {bank, ir[7:0]})
        else $error("banked address wrong");
    a_access_addr: assert property (DR_RE && !ir[8] && !(ext && ir[7:0] <= 8'h5f)
        |-> DR_ADDR == {(ir[7:0] >= 8'h60) ? 4'hf : 4'h0, ir[7:0]})
        else $error("access bank address wrong");
    a_indexed_addr: assert property (DR_RE && !ir[8] && ext && ir[7:0] <= 8'h5f
        |-> DR_ADDR == base + {4'h0, ir[7:0]})
        else $error("indexed offset address wrong");
    a_bit_clear_data: assert property (DR_WE && ir[15:12] == 4'h9
        |-> DR_WDATA == ($past(DR_RDATA) & ~(8'h01 << ir[11:9])))
        else $error("bit clear write data wrong");
    // Carry is taken as it stood during the write phase, before any same-edge software write.
    a_branch_target: assert property ($changed(PM_ADDR) && ir[15:8] == 8'he2
        |-> PM_ADDR == $past(PM_ADDR) + ($past(carry) ? {{12{ir[7]}}, ir[7:0], 1'b0} : 21'h2))
        else $error("branch target wrong");
    a_fetch_step: assert property ($changed(PM_ADDR) && ir[15:8] != 8'he2
        |-> PM_ADDR == $past(PM_ADDR) + 21'h2)
        else $error("fetch address did not step by two");
    a_cycle_length: assert property ($changed(PM_ADDR) |=> $stable(PM_ADDR) [*3])
        else $error("instruction cycle shorter than four clocks");
    a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data not zero outside read cycle");
endmodule : abx_core_properties

bind abx_core abx_core_properties i_props (
    .CLK(CLK), .RST(RST), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA), .DR_ADDR(DR_ADDR),
    .DR_RE(DR_RE), .DR_RDATA(DR_RDATA), .DR_WE(DR_WE), .DR_WDATA(DR_WDATA),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA)
);

// file: testbench/abx_mem_model.sv
`timescale 1ns/1ps

module abx_mem_model (
    input  wire logic        clk,      // Core clock.
    input  wire logic [20:0] pm_addr,  // Fetch byte address.
    output logic      [15:0] pm_data,  // Program word.
    input  wire logic [11:0] dr_addr,  // Data address.
    input  wire logic        dr_re,    // Read strobe.
    output logic      [7:0]  dr_rdata, // Read data.
    input  wire logic        dr_we,    // Write strobe.
    input  wire logic [7:0]  dr_wdata  // Write data.
);
    logic [15:0] pmem [0:63];
    logic [7:0]  dmem [0:4095];
    logic [7:0]  rd_q  = 8'h00;
    logic        rd_ok = 1'b0;

    // Words beyond the loaded program read as zero, which the core runs as no-operation.
    assign pm_data  = (pm_addr < 21'h000080) ? pmem[pm_addr[6:1]] : 16'h0000;
    // Outside its one valid cycle the read bus shows the inverse of the last value.
    assign dr_rdata = rd_ok ? rd_q : ~rd_q;

    always @(posedge clk) begin
        rd_ok <= dr_re;
        if (dr_re) rd_q <= dmem[dr_addr];
        if (dr_we) dmem[dr_addr] <= dr_wdata;
    end
endmodule : abx_mem_model

// file: testbench/abx_core_tb.sv
`timescale 1ns/1ps

module abx_core_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, dr_re, dr_we;
    logic [20:0] pm_addr;
    logic [15:0] pm_data;
    logic [11:0] dr_addr, a1, a2, a3, a4, base;
    logic [7:0]  dr_rdata, dr_wdata, acc0, acc2, acc3, k1, k2, f1, f2, m1, r2, e3, e4;
    logic [3:0]  bank;
    logic [2:0]  b1;
    logic [7:0]  rst_addr [0:6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h20};
    int          err_total = 0, checks_done = 0, cycles = 0;

    always #2 clk = ~clk;

    abx_core i_dut (.CLK(clk), .RST(rst), .PM_ADDR(pm_addr), .PM_DATA(pm_data),
        .DR_ADDR(dr_addr), .DR_RE(dr_re), .DR_RDATA(dr_rdata), .DR_WE(dr_we),
        .DR_WDATA(dr_wdata), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
    abx_mem_model i_mem (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data),
        .dr_addr(dr_addr), .dr_re(dr_re), .dr_rdata(dr_rdata), .dr_we(dr_we),
        .dr_wdata(dr_wdata));

    function automatic logic [7:0] stat_of(input logic [7:0] r, input logic c);
        return {3'b000, r[7], 1'b0, r == 8'h00, 1'b0, c};
    endfunction : stat_of

    function automatic logic [7:0] clr_bit(input logic [7:0] v, input logic [2:0] b);
        return v & ~(8'h01 << b);
    endfunction : clr_bit

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_wr_t(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_wr_t

    task automatic reg_rd_t(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_rd_t

    task automatic wait_pc(input logic [20:0] target);
        do @(negedge clk); while (pm_addr !== target);
    endtask : wait_pc

    task automatic complete_run();
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(79885));
        for (int i = 0; i < 4096; i++) i_mem.dmem[i] = 8'($urandom);
        for (int i = 0; i < 64; i++) i_mem.pmem[i] = 16'h0000;
        {acc0, k1, k2, f1} = 32'($urandom);
        f2   = 8'h60 + 8'($urandom % 160);
        bank = 4'h1 + 4'($urandom % 13);
        base = 12'he00 + 12'($urandom % 128);
        b1   = 3'($urandom);
        a1 = {bank, f1};
        a2 = {4'hf, f2};
        a3 = base + 12'h05f;
        a4 = {bank, f1 ^ 8'h80};
        i_mem.pmem[0]  = {8'h0b, k1};
        i_mem.pmem[1]  = {6'h05, 2'b01, f1};
        i_mem.pmem[2]  = {6'h05, 2'b10, f2};
        i_mem.pmem[3]  = {4'h9, b1, 1'b0, 8'h5f};
        i_mem.pmem[4]  = {4'h9, 3'h7, 1'b1, f1 ^ 8'h80};
        i_mem.pmem[5]  = 16'he202;
        i_mem.pmem[6]  = 16'h0b00;
        i_mem.pmem[7]  = 16'h0b00;
        i_mem.pmem[8]  = 16'he2ff;
        i_mem.pmem[9]  = {8'h0b, k2};
        i_mem.pmem[10] = 16'he205;
        m1   = i_mem.dmem[a1];
        acc2 = acc0 & k1 & m1;
        r2   = acc2 & i_mem.dmem[a2];
        e3   = clr_bit(i_mem.dmem[a3], b1);
        e4   = clr_bit(i_mem.dmem[a4], 3'h7);
        acc3 = acc2 & k2;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // ------------------------------------------------------------
        // Reset values, unmapped and read-only places
        // ------------------------------------------------------------
        reg_wr_t(8'h20, 8'hff);
        reg_wr_t(abx_pkg::REG_PC_LO, 8'hff);
        foreach (rst_addr[i]) begin
            reg_rd_t(rst_addr[i], rd);
            check("reset register", rd, 8'h00);
        end
        // ------------------------------------------------------------
        // Program run: taken branch, flag hold and untaken branch
        // ------------------------------------------------------------
        reg_wr_t(abx_pkg::REG_ACC, acc0);
        reg_wr_t(abx_pkg::REG_BANK, {4'h0, bank});
        reg_wr_t(abx_pkg::REG_IDX_LO, base[7:0]);
        reg_wr_t(abx_pkg::REG_IDX_HI, {4'h0, base[11:8]});
        reg_wr_t(abx_pkg::REG_STATUS, 8'h01);
        reg_rd_t(abx_pkg::REG_BANK, rd);
        check("bank", rd, {4'h0, bank});
        reg_wr_t(abx_pkg::REG_CTRL, 8'h03);
        wait_pc(21'h000010);
        reg_rd_t(abx_pkg::REG_STATUS, rd);
        check("status after taken", rd, stat_of(r2, 1'b1));
        reg_wr_t(abx_pkg::REG_STATUS, stat_of(r2, 1'b0));
        wait_pc(21'h00001a);
        reg_rd_t(abx_pkg::REG_ACC, rd);
        check("acc", rd, acc3);
        reg_rd_t(abx_pkg::REG_STATUS, rd);
        check("status", rd, stat_of(acc3, 1'b0));
        check("source kept", i_mem.dmem[a1], m1);
        check("and write back", i_mem.dmem[a2], r2);
        check("indexed clear", i_mem.dmem[a3], e3);
        check("banked clear", i_mem.dmem[a4], e4);
        complete_run();
    end
endmodule : abx_core_tb
